// [sar_adc_conversion_sequencer.v]
// Conversion sequencer of a 10-bit successive-approximation converter
`timescale 1ns/100ps
`default_nettype none
`include "sar_consts.vh"
module sar_adc_conversion_sequencer #(
  parameter STEP_CYCLES  = `STEP_CYCLES,
  parameter PWRUP_CYCLES = `PWRUP_CYCLES
) (
  // Clock and reset
  input  wire                    i_clk,
  input  wire                    i_rst_n,
  // Host control
  input  wire                    i_convert_start_n,
  // Comparator from analog core
  input  wire                    i_comp_high,
  // Status to host and analog core
  output wire                    o_busy,
  output reg                     o_powered,
  output wire                    o_hold,
  output reg  [`RESULT_BITS-1:0] o_dac_code,
  output reg                     o_auto_pd,
  // Result read stream
  output wire                    o_result_valid,
  output wire [`BUS_BITS-1:0]    o_result_bus,
  input  wire                    i_result_ready
);
  localparam ST_IDLE = `ST_IDLE;
  localparam ST_CONV = `ST_CONV;
  localparam ST_DONE = `ST_DONE;
  localparam [3:0] MSB_IDX = `RESULT_BITS - 1;

  reg                    rst_meta;
  reg                    rst_sync;
  reg                    start_q;
  reg                    gated_q;
  reg  [15:0]            pulse_cnt;
  reg  [15:0]            step_cnt;
  reg  [3:0]             bit_idx;
  reg  [1:0]             state;
  reg  [`RESULT_BITS-1:0] result;
  reg                    push_msb;
  reg                    push_lsb;
  wire                   int_start;
  wire                   gated;
  wire                   start_rise;
  wire                   int_rise;
  wire                   gated_fall;
  wire                   step_tick;
  wire                   buf_ready;
  wire [`BUS_BITS-1:0]   push_data;
  wire [`RESULT_BITS-1:0] trial;

  function [`RESULT_BITS-1:0] bit_mask;
    input [3:0] idx;
    begin
      bit_mask = `ONE_RESULT << idx;
    end
  endfunction

  // Reset release through two flip-flops
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  assign int_start  = (pulse_cnt != 16'h0000);
  assign gated      = i_convert_start_n | int_start;
  assign start_rise = i_convert_start_n & ~start_q;
  assign int_rise   = start_rise & ~int_start;
  assign gated_fall = gated_q & ~gated;
  assign step_tick  = (step_cnt == 16'h0000);
  assign o_busy     = (state != ST_IDLE);
  assign o_hold     = (state == ST_CONV);
  assign trial      = o_dac_code;

  // Edge history and the 1 us internal pulse
  always @(posedge i_clk or negedge rst_sync) begin
    if (!rst_sync) begin
      start_q   <= 1'b0;
      gated_q   <= 1'b0;
      pulse_cnt <= 16'h0000;
    end else begin
      start_q <= i_convert_start_n;
      gated_q <= gated;
      if (start_rise)
        pulse_cnt <= PWRUP_CYCLES[15:0];
      else if (int_start)
        pulse_cnt <= pulse_cnt - 16'h0001;
    end
  end

  // Power state and mode selection
  always @(posedge i_clk or negedge rst_sync) begin
    if (!rst_sync) begin
      o_powered <= 1'b0;
      o_auto_pd <= 1'b0;
    end else begin
      if (int_rise)
        o_powered <= 1'b1;
      else if (state == ST_DONE && !i_convert_start_n)
        o_powered <= 1'b0;
      if (state == ST_DONE)
        o_auto_pd <= ~i_convert_start_n;
    end
  end

  // Successive-approximation sequence
  always @(posedge i_clk or negedge rst_sync) begin
    if (!rst_sync) begin
      state      <= ST_IDLE;
      bit_idx    <= 4'h0;
      step_cnt   <= 16'h0000;
      o_dac_code <= `ZERO_RESULT;
      result     <= `ZERO_RESULT;
      push_msb   <= 1'b0;
      push_lsb   <= 1'b0;
    end else begin
      if (push_msb && buf_ready)
        push_msb <= 1'b0;
      else if (push_lsb && !push_msb && buf_ready)
        push_lsb <= 1'b0;
      case (state)
        ST_IDLE: begin
          // Falling edges during a conversion never reach here
          if (gated_fall && o_powered) begin
            state      <= ST_CONV;
            bit_idx    <= MSB_IDX;
            step_cnt   <= STEP_CYCLES[15:0] - 16'h0001;
            o_dac_code <= bit_mask(MSB_IDX);
          end
        end
        ST_CONV: begin
          if (step_tick) begin
            step_cnt <= STEP_CYCLES[15:0] - 16'h0001;
            // Keep bit when input is at or above trial level
            if (bit_idx == 4'h0) begin
              result <= i_comp_high ? trial : (trial & ~bit_mask(bit_idx));
              state  <= ST_DONE;
            end else begin
              o_dac_code <= (i_comp_high ? trial : (trial & ~bit_mask(bit_idx)))
                            | bit_mask(bit_idx - 4'h1);
              bit_idx    <= bit_idx - 4'h1;
            end
          end else begin
            step_cnt <= step_cnt - 16'h0001;
          end
        end
        ST_DONE: begin
          state      <= ST_IDLE;
          o_dac_code <= `ZERO_RESULT;
          push_msb   <= 1'b1;
          push_lsb   <= 1'b1;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // MSB byte first, then LSBs on the top lines
  assign push_data = push_msb ? result[`RESULT_BITS-1:2]
                              : {result[1:0], `LSB_PAD};

  sar_out_buffer #(
    .WIDTH(`BUS_BITS)
  ) u_out_buffer (
    .i_clk   (i_clk),
    .i_rst_n (rst_sync),
    .i_valid (push_msb | push_lsb),
    .i_data  (push_data),
    .o_ready (buf_ready),
    .o_valid (o_result_valid),
    .o_data  (o_result_bus),
    .i_ready (i_result_ready)
  );
endmodule
`default_nettype wire

// [sar_adc_conversion_sequencer_tb.sv]
// Self-checking bench for the conversion sequencer
`timescale 1ns/100ps
`default_nettype none
module sar_adc_conversion_sequencer_tb;
  logic       i_clk = 1'b0;
  logic       i_rst_n = 1'b0;
  logic       i_convert_start_n = 1'b0;
  logic       i_result_ready = 1'b0;
  logic [9:0] level = 10'h000;
  wire        comp_high, o_busy, o_powered, o_hold, o_auto_pd, o_result_valid;
  wire [9:0]  o_dac_code;
  wire [7:0]  o_result_bus;
  int         error_cnt = 0;
  int         cmp_count = 0;
  int         cycles = 0;
  always #2 i_clk = ~i_clk;
  sar_adc_conversion_sequencer #(.STEP_CYCLES(2), .PWRUP_CYCLES(6)) DUT (
    .i_clk, .i_rst_n, .i_convert_start_n, .i_comp_high(comp_high), .o_busy, .o_powered, .o_hold,
    .o_dac_code, .o_auto_pd, .o_result_valid, .o_result_bus, .i_result_ready);
  sar_analog_model u_ana (.i_level(level), .i_dac_code(o_dac_code), .o_comp_high(comp_high));
  task automatic chk(input logic ok, input string m);
    cmp_count++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask
  task automatic wait_busy(input logic v);
    int n;
    n = 0;
    while (o_busy !== v && n < 300) begin
      @(negedge i_clk);
      n++;
    end
    chk(o_busy === v, "busy wait");
  endtask
  // Drain both bytes after a stall
  task automatic rd_pair(input logic [9:0] r);
    repeat (6) @(negedge i_clk);
    chk(o_result_valid === 1'b1 && o_result_bus === r[9:2], "msb byte");
    i_result_ready = 1'b1;
    @(negedge i_clk);
    chk(o_result_valid === 1'b1 && o_result_bus === {r[1:0], 6'h00}, "lsb byte");
    @(negedge i_clk);
    i_result_ready = 1'b0;
    chk(o_result_valid === 1'b0, "not drained");
  endtask
  task automatic t_powerup;
    chk(o_powered === 1'b0 && o_busy === 1'b0, "not down");
  endtask
  task automatic t_auto(input logic [9:0] v);
    level = v;
    repeat (30) @(negedge i_clk);
    i_convert_start_n = 1'b1;
    @(negedge i_clk);
    i_convert_start_n = 1'b0;
    repeat (2) @(negedge i_clk);
    chk(o_busy === 1'b0, "early start");
    wait_busy(1'b1);
    chk(o_powered === 1'b1, "no power");
    repeat (3) @(negedge i_clk);
    i_convert_start_n = 1'b1;
    @(negedge i_clk);
    i_convert_start_n = 1'b0;
    wait_busy(1'b0);
    chk(o_auto_pd === 1'b1 && o_powered === 1'b0, "auto mode");
    rd_pair(v);
    chk(o_busy === 1'b0, "restarted");
  endtask
  task automatic t_fast(input logic [9:0] v);
    level = v;
    repeat (30) @(negedge i_clk);
    i_convert_start_n = 1'b1;
    repeat (12) @(negedge i_clk);
    chk(o_busy === 1'b0, "held start");
    i_convert_start_n = 1'b0;
    wait_busy(1'b1);
    i_convert_start_n = 1'b1;
    wait_busy(1'b0);
    chk(o_auto_pd === 1'b0 && o_powered === 1'b1, "fast mode");
    rd_pair(v);
    repeat (30) @(negedge i_clk);
    i_convert_start_n = 1'b0;
    wait_busy(1'b1);
    wait_busy(1'b0);
    chk(o_auto_pd === 1'b1 && o_powered === 1'b0, "no power-down");
    rd_pair(v);
  endtask
  task automatic finish_test;
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      error_cnt++;
      finish_test();
    end
  end
  initial begin
    repeat (4) @(negedge i_clk);
    i_rst_n = 1'b1;
    repeat (3) @(negedge i_clk);
    t_powerup();
    t_auto(10'h2c5);
    t_auto(10'h000);
    t_auto(10'h3ff);
    t_fast(10'h13a);
    finish_test();
  end
endmodule
`default_nettype wire

// [sar_analog_model.sv]
// Comparator model of the analog core
`timescale 1ns/100ps
`default_nettype none
module sar_analog_model (
  // Held level and trial code
  input  wire logic [9:0] i_level,
  input  wire logic [9:0] i_dac_code,
  // Comparator answer
  output logic            o_comp_high
);
  assign o_comp_high = (i_level >= i_dac_code);
endmodule
`default_nettype wire

// [sar_consts.vh]
// Constants for the converter sequencer
`ifndef SAR_CONSTS_VH
`define SAR_CONSTS_VH
`define CLK_PERIOD_PS     4000
`define PWRUP_TIME_NS     1000
`define PWRUP_CYCLES      ((`PWRUP_TIME_NS * 1000) / `CLK_PERIOD_PS)
`define RESULT_BITS       10
`define BUS_BITS          8
`define STEP_CYCLES       8
`define ST_IDLE           2'h0
`define ST_CONV           2'h1
`define ST_DONE           2'h2
`define LSB_PAD           6'h00
`define ZERO_RESULT       10'h000
`define ONE_RESULT        10'h001
`define ZERO_BYTE         8'h00
`define BUF_DEPTH         2
`endif

// [sar_out_buffer.v]
// Two-entry result buffer with valid and ready on both sides
`timescale 1ns/100ps
`default_nettype none
`include "sar_consts.vh"
module sar_out_buffer #(
  parameter WIDTH = 8
) (
  // Clock and reset
  input  wire             i_clk,
  input  wire             i_rst_n,
  // Fill side
  input  wire             i_valid,
  input  wire [WIDTH-1:0] i_data,
  output wire             o_ready,
  // Drain side
  output wire             o_valid,
  output reg  [WIDTH-1:0] o_data,
  input  wire             i_ready
);
  reg [WIDTH-1:0] slot1;
  reg [1:0]       count;
  wire            push;
  wire            pop;

  assign o_ready = (count != 2'h2);
  assign o_valid = (count != 2'h0);
  assign push    = i_valid & o_ready;
  assign pop     = o_valid & i_ready;

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      count  <= 2'h0;
      o_data <= {WIDTH{1'b0}};
      slot1  <= {WIDTH{1'b0}};
    end else begin
      // Head in o_data, second entry in slot1
      case ({push, pop})
        2'b10: begin
          if (count == 2'h0) o_data <= i_data;
          else slot1 <= i_data;
          count <= count + 2'h1;
        end
        2'b01: begin
          o_data <= slot1;
          count  <= count - 2'h1;
        end
        2'b11: begin
          if (count == 2'h1) o_data <= i_data;
          else begin
            o_data <= slot1;
            slot1  <= i_data;
          end
        end
        default: begin
          count <= count;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// [sar_seq_asserts.sv]
// Checker for the conversion sequencer ports
`timescale 1ns/100ps
`default_nettype none
module sar_seq_asserts #(
  parameter STEP_CYCLES = 8
) (
  // Watched ports
  input wire logic       i_clk,
  input wire logic       i_rst_n,
  input wire logic       i_convert_start_n,
  input wire logic       o_busy,
  input wire logic       o_powered,
  input wire logic       o_hold,
  input wire logic [9:0] o_dac_code,
  input wire logic       o_auto_pd
);
  logic [15:0] bcnt;
  // Busy length counter
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) bcnt <= 16'h0000;
    else bcnt <= o_busy ? bcnt + 16'h0001 : 16'h0000;
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  property p_len; $fell(o_busy) |-> bcnt == 10 * STEP_CYCLES + 1; endproperty
  a_len: assert property (p_len)
    else $error("busy length");
  property p_trk; !o_busy |-> !o_hold && o_dac_code == 10'h000; endproperty
  a_trk: assert property (p_trk)
    else $error("not tracking");
  property p_msb; $rose(o_hold) |-> o_dac_code == 10'h200; endproperty
  a_msb: assert property (p_msb)
    else $error("first trial");
  property p_rise; $rose(o_busy) |-> o_hold && $past(o_powered) && !$past(i_convert_start_n); endproperty
  a_rise: assert property (p_rise)
    else $error("bad start");
  property p_mode; $fell(o_busy) |-> o_auto_pd == !$past(i_convert_start_n); endproperty
  a_mode: assert property (p_mode)
    else $error("mode");
  property p_pd; $fell(o_busy) && !$past(i_convert_start_n) |-> !o_powered; endproperty
  a_pd: assert property (p_pd)
    else $error("no power-down");
  property p_stay; $fell(o_busy) && $past(i_convert_start_n) |-> o_powered; endproperty
  a_stay: assert property (p_stay)
    else $error("powered off");
  property p_pup; $rose(i_convert_start_n) && !o_busy |-> ##[1:6] o_powered; endproperty
  a_pup: assert property (p_pup)
    else $error("no power-up");
endmodule
bind sar_adc_conversion_sequencer sar_seq_asserts #(.STEP_CYCLES(STEP_CYCLES)) u_chk (
  .i_clk, .i_rst_n, .i_convert_start_n, .o_busy, .o_powered, .o_hold, .o_dac_code, .o_auto_pd);
`default_nettype wire
